//--- rtl/fsw_pkg.sv
// Shared constants and types for the flash row writer.
// Assumes both ends are built from this package alone.
package fsw_pkg;
    // ------------------------------------------------------------
    // Device register indices on the slot port
    // ------------------------------------------------------------
    localparam logic [2:0] REG_UNLOCK_KEY = 3'h0;
    localparam logic [2:0] REG_CONTROL = 3'h1;
    localparam logic [2:0] REG_ADDR_LOW = 3'h2;
    localparam logic [2:0] REG_ADDR_HIGH = 3'h3;
    localparam logic [2:0] REG_DATA_LOW = 3'h4;
    localparam logic [2:0] REG_DATA_HIGH = 3'h5;
    // ------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------
    localparam int CTL_TOP_BIT = 7;
    localparam int CTL_CFG_BIT = 6;
    localparam int CTL_LATCH_ONLY_BIT = 5;
    localparam int CTL_FAIL_BIT = 3;
    localparam int CTL_ENABLE_BIT = 2;
    localparam int CTL_GO_BIT = 1;
    localparam logic [7:0] CTL_RESET = 8'h80;
    localparam logic [7:0] ADDR_HIGH_RESET = 8'h80;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    // ------------------------------------------------------------
    // Unlock pattern and row geometry
    // ------------------------------------------------------------
    localparam logic [7:0] KEY_FIRST = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'hAA;
    localparam int ROW_WORDS = 32;
    localparam int LATCH_IDX_W = 5;
    localparam int WORD_W = 14;
    localparam int ROW_ADDR_W = 10;
    localparam int FORCED_NOPS = 2;
    // ------------------------------------------------------------
    // Controller APB map
    // ------------------------------------------------------------
    localparam logic [7:0] APB_CMD = 8'h00;
    localparam logic [7:0] APB_STATUS = 8'h04;
    localparam logic [7:0] APB_RDATA = 8'h08;
    localparam int CMD_WE_BIT = 16;
    localparam int CMD_ADDR_LSB = 8;
    localparam int STS_PENDING_BIT = 0;
    localparam int STS_STALL_BIT = 1;
    localparam int STS_NOP_BIT = 2;
    localparam logic [31:0] WORD_RESET = 32'h0000_0000;

    typedef enum logic [2:0] {
        UNL_IDLE = 3'b001,
        UNL_HALF = 3'b010,
        UNL_ARMED = 3'b100
    } fsw_unlock_t;

    typedef enum logic [4:0] {
        SEQ_IDLE = 5'b00001,
        SEQ_NOP1 = 5'b00010,
        SEQ_NOP2 = 5'b00100,
        SEQ_START = 5'b01000,
        SEQ_WAIT = 5'b10000
    } fsw_seq_t;
endpackage

//--- rtl/fsw_if.sv
// Slot port between the processor core and the flash writer.
// Assumes one clock shared by both ends.
`timescale 1ns/100ps
interface fsw_if;
    logic op_valid;
    logic op_ready;
    logic op_we;
    logic [2:0] op_addr;
    logic [7:0] op_wdata;
    logic [7:0] op_rdata;
    logic rd_valid;
    logic nop_slot;
    logic stall;

    modport dev (
        input op_valid, op_we, op_addr, op_wdata,
        output op_ready, op_rdata, rd_valid, nop_slot, stall
    );
    modport core (
        output op_valid, op_we, op_addr, op_wdata,
        input op_ready, op_rdata, rd_valid, nop_slot, stall
    );
endinterface

//--- rtl/fsw_unlock.sv
// Unlock pattern tracker of the flash writer.
// Assumes op_take marks each slot accepted by the device.
`timescale 1ns/100ps
module fsw_unlock
    import fsw_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic op_take,
    input wire logic key_wr,
    input wire logic [7:0] wdata,
    output logic armed
);
    fsw_unlock_t state_q;

    // Any slot other than the next pattern step drops the arming
    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= UNL_IDLE;
        end else if (op_take) begin
            if (key_wr && wdata == KEY_FIRST) begin
                state_q <= UNL_HALF;
            end else if (key_wr && wdata == KEY_SECOND && state_q == UNL_HALF) begin
                state_q <= UNL_ARMED;
            end else begin
                state_q <= UNL_IDLE;
            end
        end
    end

    assign armed = (state_q == UNL_ARMED);
endmodule // fsw_unlock

//--- rtl/fsw_device.sv
// Flash row writer: registers, unlock, write latches and sequencer.
// Assumes the flash array pulses FLASH_DONE once per row program.
// Contract
// - 55h then AAh arms program-go
// - Unlock register write-only, value not stored
// - 32 latches, picked by address bits 4:0
// - Latch-only go loads addressed latch only
// - Latch load forces two no-op slots
// - Otherwise go programs whole row at once
// - Stall until done, then resume execution
// - Words split low byte, high six bits
// - Software masks interrupts around the sequence
// - Unused top bits read as one; data high register reads bits 7:6 as zero
// - Unlock writes and go back to back
// - Software sets enable, clears config select
//
// Added by the designer: the address map and the APB interface to the registers.
`timescale 1ns/100ps
module fsw_device
    import fsw_pkg::*;
#(
    parameter int ROW_LEN = ROW_WORDS
) (
    input wire logic SYS_CLK,
    input wire logic SYS_RST,
    fsw_if.dev BUS,
    output logic FLASH_START,
    output logic [ROW_ADDR_W-1:0] FLASH_ROW,
    output logic FLASH_CFG,
    input wire logic [LATCH_IDX_W-1:0] FLASH_LATCH_IDX,
    output logic [WORD_W-1:0] FLASH_LATCH_WORD,
    input wire logic FLASH_DONE,
    output logic BUSY
);
    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic cfg_sel_q;
    logic latch_only_q;
    logic fail_q;
    logic enable_q;
    logic go_q;
    logic [7:0] addr_low_q;
    logic [6:0] addr_high_q;
    logic [7:0] data_low_q;
    logic [5:0] data_high_q;
    logic [7:0] rdata_q;
    logic rd_valid_q;
    logic [WORD_W-1:0] latch_word_q;
    logic [WORD_W-1:0] latches [ROW_LEN];
    logic load_mode_q;
    logic [ROW_ADDR_W-1:0] row_q;
    fsw_seq_t seq_q;
    logic armed;
    logic op_take;
    logic ctl_wr;
    logic go_req;
    logic go_ok;

    function automatic logic is_wr(input logic [2:0] idx, input logic take, input logic we,
                                   input logic [2:0] a);
        return take && we && (a == idx);
    endfunction

    assign op_take = BUS.op_valid && BUS.op_ready;
    assign ctl_wr = is_wr(REG_CONTROL, op_take, BUS.op_we, BUS.op_addr);
    assign go_req = ctl_wr && BUS.op_wdata[CTL_GO_BIT];
    // Enable is the value already stored, so one write cannot set both
    assign go_ok = go_req && armed && enable_q && seq_q == SEQ_IDLE;

    // ------------------------------------------------------------
    // Unlock tracking
    // ------------------------------------------------------------
    fsw_unlock i_fsw_unlock (
        .clk(SYS_CLK),
        .rst(SYS_RST),
        .op_take(op_take),
        .key_wr(is_wr(REG_UNLOCK_KEY, op_take, BUS.op_we, BUS.op_addr)),
        .wdata(BUS.op_wdata),
        .armed(armed)
    );

    // ------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            cfg_sel_q <= CTL_RESET[CTL_CFG_BIT];
            latch_only_q <= CTL_RESET[CTL_LATCH_ONLY_BIT];
            enable_q <= CTL_RESET[CTL_ENABLE_BIT];
        end else if (ctl_wr) begin
            cfg_sel_q <= BUS.op_wdata[CTL_CFG_BIT];
            latch_only_q <= BUS.op_wdata[CTL_LATCH_ONLY_BIT];
            enable_q <= BUS.op_wdata[CTL_ENABLE_BIT];
        end
    end

    // Refused go raises the fail flag; a refusal beats a clear
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            fail_q <= CTL_RESET[CTL_FAIL_BIT];
        end else if (go_req && !go_ok) begin
            fail_q <= 1'b1;
        end else if (ctl_wr) begin
            fail_q <= BUS.op_wdata[CTL_FAIL_BIT];
        end
    end

    // Go can only be set by hardware acceptance, cleared at the end
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            go_q <= CTL_RESET[CTL_GO_BIT];
        end else if (go_ok) begin
            go_q <= 1'b1;
        end else if ((seq_q == SEQ_NOP2 && load_mode_q) || (seq_q == SEQ_WAIT && FLASH_DONE)) begin
            go_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Address and data registers
    // ------------------------------------------------------------
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            addr_low_q <= BYTE_RESET;
            addr_high_q <= ADDR_HIGH_RESET[6:0];
            data_low_q <= BYTE_RESET;
            data_high_q <= BYTE_RESET[5:0];
        end else begin
            if (is_wr(REG_ADDR_LOW, op_take, BUS.op_we, BUS.op_addr)) begin
                addr_low_q <= BUS.op_wdata;
            end
            if (is_wr(REG_ADDR_HIGH, op_take, BUS.op_we, BUS.op_addr)) begin
                addr_high_q <= BUS.op_wdata[6:0];
            end
            if (is_wr(REG_DATA_LOW, op_take, BUS.op_we, BUS.op_addr)) begin
                data_low_q <= BUS.op_wdata;
            end
            if (is_wr(REG_DATA_HIGH, op_take, BUS.op_we, BUS.op_addr)) begin
                data_high_q <= BUS.op_wdata[5:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Register reads, answered one cycle after the slot
    // ------------------------------------------------------------
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            rdata_q <= BYTE_RESET;
            rd_valid_q <= 1'b0;
        end else begin
            rd_valid_q <= op_take && !BUS.op_we;
            if (op_take && !BUS.op_we) begin
                unique case (BUS.op_addr)
                    REG_CONTROL: rdata_q <= {1'b1, cfg_sel_q, latch_only_q, 1'b0, fail_q,
                                             enable_q, go_q, 1'b0};
                    REG_ADDR_LOW: rdata_q <= addr_low_q;
                    REG_ADDR_HIGH: rdata_q <= {1'b1, addr_high_q};
                    REG_DATA_LOW: rdata_q <= data_low_q;
                    REG_DATA_HIGH: rdata_q <= {2'b00, data_high_q};
                    default: rdata_q <= BYTE_RESET;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Sequencer: two forced no-op slots, then stall for a row write
    // ------------------------------------------------------------
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            seq_q <= SEQ_IDLE;
            load_mode_q <= 1'b0;
            row_q <= '0;
        end else begin
            unique case (seq_q)
                SEQ_IDLE: begin
                    if (go_ok) begin
                        seq_q <= SEQ_NOP1;
                        // Mode as written with go, so it matches what control reads back
                        load_mode_q <= BUS.op_wdata[CTL_LATCH_ONLY_BIT];
                        row_q <= {addr_high_q, addr_low_q[7:LATCH_IDX_W]};
                    end
                end
                SEQ_NOP1: seq_q <= SEQ_NOP2;
                SEQ_NOP2: seq_q <= load_mode_q ? SEQ_IDLE : SEQ_START;
                SEQ_START: seq_q <= SEQ_WAIT;
                SEQ_WAIT: begin
                    if (FLASH_DONE) begin
                        seq_q <= SEQ_IDLE;
                    end
                end
            endcase
        end
    end

    // Latch written during the first forced slot; data is stable then
    always_ff @(posedge SYS_CLK) begin
        if (seq_q == SEQ_NOP1 && load_mode_q) begin
            latches[addr_low_q[LATCH_IDX_W-1:0]] <= {data_high_q, data_low_q};
        end
    end

    // Array reads the whole row through this port while programming
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            latch_word_q <= '0;
        end else begin
            latch_word_q <= latches[FLASH_LATCH_IDX];
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign BUS.op_ready = (seq_q == SEQ_IDLE);
    assign BUS.nop_slot = (seq_q == SEQ_NOP1) || (seq_q == SEQ_NOP2);
    assign BUS.stall = (seq_q == SEQ_START) || (seq_q == SEQ_WAIT);
    assign BUS.op_rdata = rdata_q;
    assign BUS.rd_valid = rd_valid_q;
    assign FLASH_START = (seq_q == SEQ_START);
    assign FLASH_ROW = row_q;
    assign FLASH_CFG = cfg_sel_q;
    assign FLASH_LATCH_WORD = latch_word_q;
    assign BUSY = go_q;
endmodule // fsw_device

//--- rtl/fsw_core.sv
// Core-side end: turns APB commands into register slots.
// Assumes software issues unlock writes and go back to back.
`timescale 1ns/100ps
module fsw_core
    import fsw_pkg::*;
(
    input wire logic SYS_CLK,
    input wire logic SYS_RST,
    fsw_if.core BUS,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR
);
    logic pend_q;
    logic we_q;
    logic [2:0] addr_q;
    logic [7:0] wdata_q;
    logic [7:0] rd_q;
    logic [31:0] prdata_q;
    logic access;
    logic cmd_wr;
    logic mapped;

    assign access = PSEL && PENABLE;
    assign mapped = (PADDR == APB_CMD) || (PADDR == APB_STATUS) || (PADDR == APB_RDATA);
    assign cmd_wr = access && PWRITE && PADDR == APB_CMD;
    // A new command waits until the previous slot was taken
    assign PREADY = access && !(cmd_wr && pend_q);
    assign PSLVERR = PREADY && !mapped;

    // ------------------------------------------------------------
    // One pending slot request
    // ------------------------------------------------------------
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            pend_q <= 1'b0;
            we_q <= 1'b0;
            addr_q <= '0;
            wdata_q <= BYTE_RESET;
        end else if (cmd_wr && !pend_q) begin
            pend_q <= 1'b1;
            we_q <= PWDATA[CMD_WE_BIT];
            addr_q <= PWDATA[CMD_ADDR_LSB+2:CMD_ADDR_LSB];
            wdata_q <= PWDATA[7:0];
        end else if (BUS.op_ready) begin
            pend_q <= 1'b0;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            rd_q <= BYTE_RESET;
        end else if (BUS.rd_valid) begin
            rd_q <= BUS.op_rdata;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            prdata_q <= WORD_RESET;
        end else if (PSEL && !PENABLE && !PWRITE) begin
            unique case (PADDR)
                APB_STATUS: prdata_q <= {29'h0, BUS.nop_slot, BUS.stall, pend_q};
                APB_RDATA: prdata_q <= {24'h0, rd_q};
                APB_CMD: prdata_q <= {15'h0, we_q, 5'h0, addr_q, wdata_q};
                default: prdata_q <= WORD_RESET;
            endcase
        end
    end

    assign PRDATA = prdata_q;
    assign BUS.op_valid = pend_q;
    assign BUS.op_we = we_q;
    assign BUS.op_addr = addr_q;
    assign BUS.op_wdata = wdata_q;
endmodule // fsw_core

//--- testbench/fsw_props.sv
// Checker on the slot port between the core end and the flash writer.
// Assumes it sits beside the interface in the bench top, one clock.
`timescale 1ns/100ps
module fsw_props
    import fsw_pkg::*;
(
    input wire logic SYS_CLK,
    input wire logic SYS_RST,
    input wire logic op_valid,
    input wire logic op_ready,
    input wire logic op_we,
    input wire logic [2:0] op_addr,
    input wire logic [7:0] op_wdata,
    input wire logic [7:0] op_rdata,
    input wire logic rd_valid,
    input wire logic nop_slot,
    input wire logic stall,
    input wire logic FLASH_START,
    input wire logic FLASH_DONE
);
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (SYS_RST);
    // ------------------------------
    // Unlock tracking on taken slots
    // ------------------------------
    logic [1:0] stage_q;
    logic en_q;
    logic take;
    logic rd_take;
    logic key_wr;
    logic ctl_wr;
    logic go_ok;
    logic go_bad;
    assign take = op_valid && op_ready;
    assign rd_take = take && !op_we;
    assign key_wr = take && op_we && op_addr == REG_UNLOCK_KEY;
    assign ctl_wr = take && op_we && op_addr == REG_CONTROL;
    assign go_ok = ctl_wr && op_wdata[CTL_GO_BIT] && stage_q == 2'h2 && en_q;
    assign go_bad = ctl_wr && op_wdata[CTL_GO_BIT] && !go_ok;
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST)
            stage_q <= 2'h0;
        else if (key_wr && op_wdata == KEY_FIRST)
            stage_q <= 2'h1;
        else if (key_wr && op_wdata == KEY_SECOND && stage_q == 2'h1)
            stage_q <= 2'h2;
        else if (take)
            stage_q <= 2'h0;
    end
    // Enable counts only if stored before the go
    always_ff @(posedge SYS_CLK) begin
        if (SYS_RST)
            en_q <= 1'h0;
        else if (ctl_wr)
            en_q <= op_wdata[CTL_ENABLE_BIT];
    end
    property p_key_zero;
        rd_take && op_addr == REG_UNLOCK_KEY |=> rd_valid && op_rdata == BYTE_RESET;
    endproperty
    a_key_zero: assert property (p_key_zero) else $error("key read not zero");
    property p_top_one;
        rd_take && (op_addr == REG_CONTROL || op_addr == REG_ADDR_HIGH) |=> op_rdata[7];
    endproperty
    a_top_one: assert property (p_top_one) else $error("top bit not one");
    property p_go_nops;
        go_ok |=> nop_slot && !op_ready ##1 nop_slot && !op_ready ##1 !nop_slot;
    endproperty
    a_go_nops: assert property (p_go_nops) else $error("forced slots wrong");
    property p_refused;
        go_bad |=> !nop_slot [*3];
    endproperty
    a_refused: assert property (p_refused) else $error("refused go acted");
    property p_latch_only;
        go_ok && op_wdata[CTL_LATCH_ONLY_BIT] |=> !FLASH_START [*2] ##1
            !FLASH_START && op_ready && !stall;
    endproperty
    a_latch_only: assert property (p_latch_only) else $error("latch load wrong");
    property p_row_start;
        go_ok && !op_wdata[CTL_LATCH_ONLY_BIT] |=> ##2 FLASH_START && stall;
    endproperty
    a_row_start: assert property (p_row_start) else $error("row start wrong");
    property p_stall_hold;
        stall && !FLASH_DONE |=> stall && !op_ready;
    endproperty
    a_stall_hold: assert property (p_stall_hold) else $error("stall dropped");
    property p_stall_end;
        stall && FLASH_DONE |=> !stall && op_ready;
    endproperty
    a_stall_end: assert property (p_stall_end) else $error("stall not ended");
endmodule // fsw_props

//--- testbench/program_flash_row_writer_tb.sv
// Bench: APB master on the core end, flash array model on the device.
// Assumes both ends joined by fsw_if, checker instantiated beside it.
`timescale 1ns/100ps
module program_flash_row_writer_tb
    import fsw_pkg::*;
;
    logic SYS_CLK = 1'h0;
    logic SYS_RST = 1'h1;
    logic PSEL = 1'h0;
    logic PENABLE = 1'h0;
    logic PWRITE = 1'h0;
    logic [7:0] PADDR = 8'h00;
    logic [31:0] PWDATA = 32'h0;
    logic [31:0] PRDATA;
    logic PREADY;
    logic PSLVERR;
    logic FLASH_START;
    logic [ROW_ADDR_W-1:0] FLASH_ROW;
    logic FLASH_CFG;
    logic [LATCH_IDX_W-1:0] FLASH_LATCH_IDX = '0;
    logic [WORD_W-1:0] FLASH_LATCH_WORD;
    logic FLASH_DONE = 1'h0;
    logic BUSY;
    logic [31:0] rdata;
    logic err;
    logic [7:0] bl;
    logic [7:0] bh;
    logic [WORD_W-1:0] exp_row [ROW_WORDS];
    logic [7:0] rst_val [6] = '{8'h00, CTL_RESET, 8'h00, ADDR_HIGH_RESET, 8'h00, 8'h00};
    int miscompares = 0;
    int n_tests = 0;
    int n_start = 0;
    int cycles = 0;

    fsw_if bus ();
    fsw_core i_fsw_core (.SYS_CLK, .SYS_RST, .BUS(bus), .PSEL, .PENABLE, .PWRITE,
        .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR);
    fsw_device i_fsw_device (.SYS_CLK, .SYS_RST, .BUS(bus), .FLASH_START, .FLASH_ROW,
        .FLASH_CFG, .FLASH_LATCH_IDX, .FLASH_LATCH_WORD, .FLASH_DONE, .BUSY);
    fsw_props i_fsw_props (.SYS_CLK, .SYS_RST, .op_valid(bus.op_valid),
        .op_ready(bus.op_ready), .op_we(bus.op_we), .op_addr(bus.op_addr),
        .op_wdata(bus.op_wdata), .op_rdata(bus.op_rdata), .rd_valid(bus.rd_valid),
        .nop_slot(bus.nop_slot), .stall(bus.stall), .FLASH_START, .FLASH_DONE);

    always #2.5 SYS_CLK = ~SYS_CLK;

    // ------------------------------
    // Tasks
    // ------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic results();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Idle cycle at the end keeps each driver change one per time step
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        PSEL <= 1'h1;
        PWRITE <= wr;
        PADDR <= a;
        PWDATA <= d;
        @(posedge SYS_CLK);
        PENABLE <= 1'h1;
        do
            @(posedge SYS_CLK);
        while (PREADY !== 1'h1);
        rdata = PRDATA;
        err = PSLVERR;
        PSEL <= 1'h0;
        PENABLE <= 1'h0;
        @(posedge SYS_CLK);
    endtask

    task automatic dwr(input logic [2:0] idx, input logic [7:0] v);
        apb(1'h1, APB_CMD, {15'h0, 1'h1, 5'h0, idx, v});
    endtask

    task automatic drd(input logic [2:0] idx, input logic [7:0] exp);
        apb(1'h1, APB_CMD, {15'h0, 1'h0, 5'h0, idx, 8'h00});
        do
            apb(1'h0, APB_STATUS, 32'h0);
        while (rdata[STS_PENDING_BIT] !== 1'h0);
        apb(1'h0, APB_RDATA, 32'h0);
        check({24'h0, rdata[7:0]}, {24'h0, exp});
    endtask

    task automatic go(input logic [7:0] ctl);
        dwr(REG_UNLOCK_KEY, KEY_FIRST);
        dwr(REG_UNLOCK_KEY, KEY_SECOND);
        dwr(REG_CONTROL, ctl);
    endtask

    // Flash array: reads the row back through the latch index, then done
    always begin
        @(posedge SYS_CLK);
        if (FLASH_START === 1'h1) begin
            n_start++;
            check({22'h0, FLASH_ROW}, 32'h0000_002A);
            check({31'h0, FLASH_CFG}, 32'h0);
            check({31'h0, BUSY}, 32'h1);
            for (int j = 0; j < ROW_WORDS; j++) begin
                FLASH_LATCH_IDX <= j[LATCH_IDX_W-1:0];
                @(posedge SYS_CLK);
                @(posedge SYS_CLK);
                check({18'h0, FLASH_LATCH_WORD}, {18'h0, exp_row[j]});
            end
            FLASH_DONE <= 1'h1;
            @(posedge SYS_CLK);
            FLASH_DONE <= 1'h0;
        end
    end

    always @(posedge SYS_CLK) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares++;
            results();
        end
    end

    // ------------------------------
    // Scenarios
    // ------------------------------
    initial begin
        repeat (8) @(posedge SYS_CLK);
        SYS_RST <= 1'h0;
        @(posedge SYS_CLK);
        for (int k = 0; k < 6; k++)
            drd(k[2:0], rst_val[k]);
        apb(1'h0, 8'h0C, 32'h0);
        check({31'h0, err}, 32'h1);
        dwr(REG_DATA_HIGH, 8'hFF);
        drd(REG_DATA_HIGH, 8'h3F);
        dwr(REG_CONTROL, 8'h04);
        dwr(REG_CONTROL, 8'h06);
        drd(REG_CONTROL, 8'h8C);
        dwr(REG_ADDR_HIGH, 8'h05);
        drd(REG_ADDR_HIGH, 8'h85);
        dwr(REG_CONTROL, 8'h24);
        for (int k = 0; k < ROW_WORDS; k++) begin
            bl = 8'h5A ^ (k[7:0] * 8'h07);
            bh = 8'hC0 | (8'h2A ^ k[7:0]);
            exp_row[k] = {bh[5:0], bl};
            dwr(REG_ADDR_LOW, 8'h40 | k[7:0]);
            dwr(REG_DATA_LOW, bl);
            dwr(REG_DATA_HIGH, bh);
            go(8'h26);
        end
        check(n_start, 32'h0);
        drd(REG_CONTROL, 8'hA4);
        // Broken pattern must leave latch 0 alone
        dwr(REG_ADDR_LOW, 8'h40);
        dwr(REG_DATA_LOW, 8'h00);
        dwr(REG_UNLOCK_KEY, KEY_FIRST);
        dwr(REG_UNLOCK_KEY, 8'h00);
        dwr(REG_UNLOCK_KEY, KEY_SECOND);
        dwr(REG_CONTROL, 8'h26);
        drd(REG_CONTROL, 8'hAC);
        dwr(REG_CONTROL, 8'h20);
        go(8'h22);
        drd(REG_CONTROL, 8'hA8);
        dwr(REG_CONTROL, 8'h40);
        drd(REG_CONTROL, 8'hC0);
        dwr(REG_CONTROL, 8'h04);
        go(8'h06);
        do
            apb(1'h0, APB_STATUS, 32'h0);
        while (rdata[STS_STALL_BIT] !== 1'h1);
        check(n_start, 32'h1);
        do
            apb(1'h0, APB_STATUS, 32'h0);
        while (rdata[STS_STALL_BIT] !== 1'h0);
        drd(REG_CONTROL, 8'h84);
        check({31'h0, BUSY}, 32'h0);
        results();
    end
endmodule // program_flash_row_writer_tb
